/* src/afd_decoder.v */
// What this block does
// - marker 80h: each following byte pair is one code point, high byte first.
// - in 80h scheme, stop at first FFFFh pair or lone FFh leftover.
// - marker 81h: byte 2 is count, byte 3 gives base bits 14..7.
// - 81h content byte with top bit clear yields a seven-bit default character.
// - 81h content byte with top bit set yields base plus low seven bits.
// - marker 82h: byte 2 is count, bytes 3 and 4 form the base, high first.
// - 82h content from byte 5: default char or base plus offset.
// - base schemes emit at most count characters; FFh within count is base+7Fh.
// - one scheme per record; default-only records carry no 80h/81h/82h marker.
// - all three 16-bit schemes are supported.
//
// Purpose: decodes an alpha field byte string into 16-bit code points
// Assumes: bytes come from same-clock logic, byte_last_in marks the final field byte
// Notes: output goes through a 16-entry fifo; no software-visible registers
`timescale 1ns/1ns
`default_nettype none
`include "afd_map.vh"

module afd_decoder (
	input wire clock_in,
	input wire reset_n_in,
	input wire [`AFD_BYTE_W-1:0] byte_in,
	input wire byte_valid_in,
	input wire byte_last_in,
	output wire byte_ready_out,
	output wire [`AFD_CP_W-1:0] char_out,
	output wire char_default_out,
	output wire char_last_out,
	output wire char_valid_out,
	input wire char_ready_in,
	output wire done_out,
	output wire busy_out,
	output wire [`AFD_SCH_W-1:0] scheme_out
);

	// ==================================================
	// states
	localparam [`AFD_ST_W-1:0] S_LEAD = 3'h0;
	localparam [`AFD_ST_W-1:0] S_PLAIN = 3'h1;
	localparam [`AFD_ST_W-1:0] S_PAIR_HI = 3'h2;
	localparam [`AFD_ST_W-1:0] S_PAIR_LO = 3'h3;
	localparam [`AFD_ST_W-1:0] S_COUNT = 3'h4;
	localparam [`AFD_ST_W-1:0] S_BASE_HI = 3'h5;
	localparam [`AFD_ST_W-1:0] S_BASE_LO = 3'h6;
	localparam [`AFD_ST_W-1:0] S_BODY = 3'h7;

	// ==================================================
	// registers and next values
	reg [`AFD_ST_W-1:0] state_r;
	reg [`AFD_ST_W-1:0] state_nxt;
	reg [`AFD_SCH_W-1:0] scheme_r;
	reg [`AFD_SCH_W-1:0] scheme_nxt;
	reg [`AFD_BYTE_W-1:0] cnt_r;
	reg [`AFD_BYTE_W-1:0] cnt_nxt;
	reg [`AFD_CP_W-1:0] base_r;
	reg [`AFD_CP_W-1:0] base_nxt;
	reg [`AFD_BYTE_W-1:0] hi_r;
	reg [`AFD_BYTE_W-1:0] hi_nxt;
	reg skip_r;
	reg skip_nxt;

	// fifo entry being built this cycle
	reg push;
	reg e_noch;
	reg e_last;
	reg e_dflt;
	reg [`AFD_CP_W-1:0] e_code;

	wire take;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire fifo_out_ready;
	wire [`AFD_ENT_W-1:0] fifo_in_data;
	wire [`AFD_ENT_W-1:0] fifo_out_data;
	wire [`AFD_CP_W-1:0] body_code;
	wire body_dflt;
	wire [`AFD_CP_W-1:0] pair_code;
	wire [`AFD_CP_W-1:0] plain_code;
	wire is_pad;
	wire out_noch;

	// ==================================================
	// input handshake
	// byte taken
	// at most one entry per byte, so a full fifo simply stalls the source
	assign byte_ready_out = fifo_in_ready;
	assign take = byte_valid_in & fifo_in_ready;
	assign is_pad = (byte_in == `AFD_PAD_BYTE);

	assign pair_code = {hi_r, byte_in};
	assign plain_code = {`AFD_ZERO8, byte_in};

	afd_cp_form u_cp_form (
		.byte_in(byte_in),
		.base_in(base_r),
		.code_out(body_code),
		.default_out(body_dflt)
	);

	// ==================================================
	// decode state machine, one byte per accepted cycle
	always @* begin
		state_nxt = state_r;
		scheme_nxt = scheme_r;
		cnt_nxt = cnt_r;
		base_nxt = base_r;
		hi_nxt = hi_r;
		skip_nxt = skip_r;
		push = 1'b0;
		e_noch = 1'b0;
		e_last = 1'b0;
		e_dflt = 1'b0;
		e_code = `AFD_ZERO16;
		if (take && skip_r) begin
			// discard bytes left after an early end of the string
			if (byte_last_in) begin
				skip_nxt = 1'b0;
				state_nxt = S_LEAD;
			end
		end else if (take) begin
			case (state_r)
				S_LEAD: begin
					if (byte_in == `AFD_MARK_UCS) begin
						scheme_nxt = `AFD_SCH_UCS;
						state_nxt = S_PAIR_HI;
					end else if (byte_in == `AFD_MARK_HALF) begin
						scheme_nxt = `AFD_SCH_HALF;
						state_nxt = S_COUNT;
					end else if (byte_in == `AFD_MARK_FULL) begin
						scheme_nxt = `AFD_SCH_FULL;
						state_nxt = S_COUNT;
					end else begin
						scheme_nxt = `AFD_SCH_DEF;
						state_nxt = S_PLAIN;
					end
					// leading byte is itself a character
					if (scheme_nxt == `AFD_SCH_DEF && !is_pad) begin
						push = 1'b1;
						e_dflt = 1'b1;
						e_code = plain_code;
						e_last = byte_last_in;
						if (byte_last_in) begin
							state_nxt = S_LEAD;
						end
					end else if (scheme_nxt == `AFD_SCH_DEF || byte_last_in) begin
						// empty string: report end without a character
						push = 1'b1;
						e_noch = 1'b1;
						e_last = 1'b1;
						skip_nxt = ~byte_last_in;
						state_nxt = S_LEAD;
					end
				end
				S_PLAIN: begin
					// pass through until padding or field end
					push = 1'b1;
					e_last = 1'b1;
					if (is_pad) begin
						e_noch = 1'b1;
						skip_nxt = ~byte_last_in;
						state_nxt = S_LEAD;
					end else begin
						e_dflt = 1'b1;
						e_code = plain_code;
						e_last = byte_last_in;
						if (byte_last_in) begin
							state_nxt = S_LEAD;
						end
					end
				end
				S_PAIR_HI: begin
					// lone last byte is padding, never half a character
					if (byte_last_in) begin
						push = 1'b1;
						e_noch = 1'b1;
						e_last = 1'b1;
						state_nxt = S_LEAD;
					end else begin
						hi_nxt = byte_in;
						state_nxt = S_PAIR_LO;
					end
				end
				S_PAIR_LO: begin
					push = 1'b1;
					// stop at the first all-ones pair
					if (pair_code == `AFD_PAD_PAIR) begin
						e_noch = 1'b1;
						e_last = 1'b1;
						skip_nxt = ~byte_last_in;
						state_nxt = S_LEAD;
					end else begin
						e_code = pair_code;
						e_last = byte_last_in;
						state_nxt = byte_last_in ? S_LEAD : S_PAIR_HI;
					end
				end
				S_COUNT: begin
					// second byte is the character count
					// same position in the full-base scheme
					cnt_nxt = byte_in;
					if (byte_in == `AFD_ZERO8 || byte_last_in) begin
						push = 1'b1;
						e_noch = 1'b1;
						e_last = 1'b1;
						skip_nxt = ~byte_last_in;
						state_nxt = S_LEAD;
					end else begin
						state_nxt = S_BASE_HI;
					end
				end
				S_BASE_HI: begin
					if (scheme_r == `AFD_SCH_HALF) begin
						// byte gives bits 14..7, top and low seven bits zero
						base_nxt = {1'b0, byte_in, `AFD_ZERO7};
						state_nxt = S_BODY;
					end else begin
						// high half of the full base
						base_nxt = {byte_in, `AFD_ZERO8};
						state_nxt = S_BASE_LO;
					end
					if (byte_last_in) begin
						push = 1'b1;
						e_noch = 1'b1;
						e_last = 1'b1;
						state_nxt = S_LEAD;
					end
				end
				S_BASE_LO: begin
					// low half of the full base
					base_nxt = {base_r[`AFD_CP_W-1:`AFD_BYTE_W], byte_in};
					state_nxt = S_BODY;
					if (byte_last_in) begin
						push = 1'b1;
						e_noch = 1'b1;
						e_last = 1'b1;
						state_nxt = S_LEAD;
					end
				end
				S_BODY: begin
					// default char when top bit clear
					// same coding from the fifth byte on
					push = 1'b1;
					e_dflt = body_dflt;
					e_code = body_code;
					// count governs the end; FFh is an ordinary offset here
					cnt_nxt = cnt_r - `AFD_ONE8;
					e_last = (cnt_r == `AFD_ONE8) | byte_last_in;
					if (cnt_r == `AFD_ONE8 || byte_last_in) begin
						skip_nxt = ~byte_last_in;
						state_nxt = S_LEAD;
					end
				end
				default: begin
					state_nxt = S_LEAD;
				end
			endcase
		end
	end

	// ==================================================
	// state registers
	always @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_r <= S_LEAD;
			scheme_r <= `AFD_SCH_DEF;
			cnt_r <= `AFD_ZERO8;
			base_r <= `AFD_ZERO16;
			hi_r <= `AFD_ZERO8;
			skip_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			scheme_r <= scheme_nxt;
			cnt_r <= cnt_nxt;
			base_r <= base_nxt;
			hi_r <= hi_nxt;
			skip_r <= skip_nxt;
		end
	end

	// ==================================================
	// output buffer
	assign fifo_in_data = {e_noch, e_last, e_dflt, e_code};

	afd_fifo #(
		.WIDTH(`AFD_ENT_W),
		.DEPTH(`AFD_FIFO_DEPTH),
		.AW(`AFD_FIFO_AW)
	) u_fifo (
		.clock_in(clock_in),
		.reset_n_in(reset_n_in),
		.in_data_in(fifo_in_data),
		.in_valid_in(push),
		.in_ready_out(fifo_in_ready),
		.out_data_out(fifo_out_data),
		.out_valid_out(fifo_out_valid),
		.out_ready_in(fifo_out_ready)
	);

	// ==================================================
	// output side
	// end markers without a character drain on their own
	assign out_noch = fifo_out_data[`AFD_E_NOCH];
	assign fifo_out_ready = char_ready_in | out_noch;
	assign char_valid_out = fifo_out_valid & ~out_noch;
	assign char_out = fifo_out_data[`AFD_CP_W-1:0];
	assign char_default_out = fifo_out_data[`AFD_E_DFLT];
	assign char_last_out = fifo_out_data[`AFD_E_LAST] & ~out_noch;
	// done when the final entry leaves
	assign done_out = fifo_out_valid & fifo_out_ready & fifo_out_data[`AFD_E_LAST];
	// busy while mid-string or while output still queued
	assign busy_out = (state_r != S_LEAD) | skip_r | fifo_out_valid;
	assign scheme_out = scheme_r;

endmodule // afd_decoder
`default_nettype wire

/* src/afd_map.vh */
// Purpose: shared constants of the alpha field decoder
// Assumes: included by bare name from every design file
// Notes: definitions only, no logic
`ifndef AFD_MAP_VH
`define AFD_MAP_VH

// ==================================================
// widths
`define AFD_BYTE_W 8
`define AFD_CP_W 16
`define AFD_OFS_W 7
`define AFD_SCH_W 2
`define AFD_ST_W 3

// ==================================================
// scheme markers and padding
`define AFD_MARK_UCS 8'h80
`define AFD_MARK_HALF 8'h81
`define AFD_MARK_FULL 8'h82
`define AFD_PAD_BYTE 8'hff
`define AFD_PAD_PAIR 16'hffff

// ==================================================
// scheme codes shown on scheme_out
`define AFD_SCH_DEF 2'h0
`define AFD_SCH_UCS 2'h1
`define AFD_SCH_HALF 2'h2
`define AFD_SCH_FULL 2'h3

// ==================================================
// small constants and reset values
`define AFD_ZERO8 8'h00
`define AFD_ONE8 8'h01
`define AFD_ZERO16 16'h0000
`define AFD_ZERO7 7'h00
`define AFD_PAD9 9'h000
`define AFD_TOP_BIT 7

// ==================================================
// fifo entry layout: {no_char, last, default, code}
`define AFD_FIFO_DEPTH 16
`define AFD_FIFO_AW 4
`define AFD_ENT_W 19
`define AFD_E_NOCH 18
`define AFD_E_LAST 17
`define AFD_E_DFLT 16

`endif

/* src/afd_fifo.v */
// Purpose: synchronous fifo between decoder and consumer
// Assumes: single clock, async active-low reset
// Notes: depth must be a power of two matching the address width
`timescale 1ns/1ns
`default_nettype none
`include "afd_map.vh"

module afd_fifo #(
	parameter WIDTH = `AFD_ENT_W,
	parameter DEPTH = `AFD_FIFO_DEPTH,
	parameter AW = `AFD_FIFO_AW
) (
	input wire clock_in,
	input wire reset_n_in,
	input wire [WIDTH-1:0] in_data_in,
	input wire in_valid_in,
	output wire in_ready_out,
	output wire [WIDTH-1:0] out_data_out,
	output wire out_valid_out,
	input wire out_ready_in
);

	// ==================================================
	// storage and pointers
	reg [WIDTH-1:0] mem_r [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_r;
	reg [AW-1:0] rd_ptr_r;
	reg [AW:0] count_r;
	wire push;
	wire pop;

	// honest full and empty from the occupancy count
	assign in_ready_out = (count_r != DEPTH[AW:0]);
	assign out_valid_out = (count_r != {(AW+1){1'b0}});
	assign push = in_valid_in & in_ready_out;
	assign pop = out_valid_out & out_ready_in;
	assign out_data_out = mem_r[rd_ptr_r];

	// write side; memory needs no reset, count guards reads
	always @(posedge clock_in) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data_in;
		end
	end

	// pointer and count update
	always @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			count_r <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
			end
			if (push && !pop) begin
				count_r <= count_r + {{AW{1'b0}}, 1'b1};
			end else if (pop && !push) begin
				count_r <= count_r - {{AW{1'b0}}, 1'b1};
			end
		end
	end

endmodule // afd_fifo
`default_nettype wire

/* src/afd_cp_form.v */
// Purpose: forms a code point from one base-pointer content byte
// Assumes: base pointer already assembled by the caller
// Notes: purely combinational
`timescale 1ns/1ns
`default_nettype none
`include "afd_map.vh"

module afd_cp_form (
	input wire [`AFD_BYTE_W-1:0] byte_in,
	input wire [`AFD_CP_W-1:0] base_in,
	output wire [`AFD_CP_W-1:0] code_out,
	output wire default_out
);

	// ==================================================
	// offset or default-alphabet character
	wire [`AFD_CP_W-1:0] low7;

	assign low7 = {`AFD_PAD9, byte_in[`AFD_OFS_W-1:0]};
	// top bit clear means a seven-bit default character
	assign default_out = ~byte_in[`AFD_TOP_BIT];
	// top bit set: sum is a complete code point, carry drops at 16 bits
	assign code_out = default_out ? low7 : (base_in + low7);

endmodule // afd_cp_form
`default_nettype wire

/* test/afd_chk_assertions.sv */
// Purpose: port checks for the alpha field decoder
// Assumes: bound to afd_decoder, one clock domain
// Notes: lead byte found by a helper flag, as busy may span strings
`timescale 1ns/1ns
`default_nettype none
`include "afd_map.vh"
// ==========
// checker
module afd_chk (
	input wire logic clock_in,
	input wire logic reset_n_in,
	input wire logic [7:0] byte_in,
	input wire logic byte_valid_in,
	input wire logic byte_last_in,
	input wire logic byte_ready_out,
	input wire logic [15:0] char_out,
	input wire logic char_default_out,
	input wire logic char_last_out,
	input wire logic char_valid_out,
	input wire logic char_ready_in,
	input wire logic done_out,
	input wire logic busy_out,
	input wire logic [1:0] scheme_out
);
	logic first_r;
	wire logic take = byte_valid_in && byte_ready_out;
	// next taken byte leads a field after reset or a last byte
	always @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			first_r <= 1'b1;
		end else if (take) begin
			first_r <= byte_last_in;
		end
	end
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!reset_n_in);
	sequence lead_s(m);
		take && first_r && byte_in == m;
	endsequence
	sequence last_take_s;
		char_valid_out && char_ready_in && char_last_out;
	endsequence
	lead_ucs_a:
	assert property (lead_s(8'h80) |-> ##[1:2] scheme_out == 2'h1) else $error("scheme not pairs");
	lead_half_a:
	assert property (lead_s(8'h81) |-> ##[1:2] scheme_out == 2'h2) else $error("scheme not half base");
	lead_full_a:
	assert property (lead_s(8'h82) |-> ##[1:2] scheme_out == 2'h3) else $error("scheme not full base");
	lead_dflt_a:
	assert property (take && first_r && byte_in[7:2] != 6'h20 |-> ##[1:2] scheme_out == 2'h0)
		else $error("scheme not default");
	last_done_a:
	assert property (last_take_s |-> ##[0:1] done_out) else $error("no done after last char");
	done_char_a:
	assert property (done_out && char_valid_out |-> char_ready_in && char_last_out)
		else $error("done while a non-final char shown");
	char_hold_a:
	assert property (char_valid_out && !char_ready_in |=> char_valid_out && $stable(char_out)
		&& $stable(char_last_out)) else $error("char dropped before taken");
	dflt_byte_a:
	assert property (char_valid_out && char_default_out |-> char_out[15:8] == 8'h00)
		else $error("default char too wide");
	idle_ready_a:
	assert property (!busy_out |-> byte_ready_out) else $error("not ready while idle");
	valid_busy_a:
	assert property (char_valid_out |-> busy_out) else $error("char shown while idle");
endmodule // afd_chk
bind afd_decoder afd_chk u_chk (.clock_in(clock_in), .reset_n_in(reset_n_in), .byte_in(byte_in),
	.byte_valid_in(byte_valid_in), .byte_last_in(byte_last_in), .byte_ready_out(byte_ready_out),
	.char_out(char_out), .char_default_out(char_default_out), .char_last_out(char_last_out),
	.char_valid_out(char_valid_out), .char_ready_in(char_ready_in), .done_out(done_out),
	.busy_out(busy_out), .scheme_out(scheme_out));
`default_nettype wire

/* test/afd_src.sv */
// Purpose: byte source standing for the record reader
// Assumes: fields queued by the bench through q
// Notes: holds each byte until taken, scrambles the bus when idle
`timescale 1ns/1ns
`default_nettype none
// ==========
// source model
module afd_src (
	input wire logic clock_in,
	input wire logic ready_in,
	input wire logic slow_in,
	output logic [7:0] byte_out = 8'h00,
	output logic valid_out = 1'b0,
	output logic last_out = 1'b0
);
	logic [8:0] q[$];
	logic took = 1'b0;
	// note an offer taken at the sampling edge
	always @(posedge clock_in) begin
		took <= valid_out && ready_in;
	end
	// fields sent whole as queued
	// moves on the falling edge, away from sampling; slow mode idles a cycle
	always @(negedge clock_in) begin
		if (took) begin
			void'(q.pop_front());
		end
		if (q.size() > 0 && !(slow_in && took)) begin
			valid_out <= 1'b1;
			{last_out, byte_out} <= q[0];
		end else begin
			valid_out <= 1'b0;
			last_out <= 1'b0;
			byte_out <= ~byte_out; // released bus never holds
		end
	end
endmodule // afd_src
`default_nettype wire

/* test/tb_afd_decoder.sv */
// Purpose: self-checking bench for the alpha field decoder
// Assumes: afd_src supplies bytes, the bench consumes chars
// Notes: expected chars worked out by hand per field
`timescale 1ns/1ns
`default_nettype none
`include "afd_map.vh"
// ==========
// bench top
module tb_afd_decoder;
	logic clock_in, reset_n_in, char_ready_in, slow, byte_valid_in, byte_last_in, byte_ready_out;
	logic [7:0] byte_in;
	logic [15:0] char_out;
	logic char_default_out, char_last_out, char_valid_out, done_out, busy_out;
	logic [1:0] scheme_out;
	logic [17:0] got[$];
	logic [17:0] exp[$];
	int error_cnt = 0;
	int samples_checked = 0;
	int dones = 0;
	afd_decoder u_dut (.clock_in(clock_in), .reset_n_in(reset_n_in), .byte_in(byte_in),
		.byte_valid_in(byte_valid_in), .byte_last_in(byte_last_in), .byte_ready_out(byte_ready_out),
		.char_out(char_out), .char_default_out(char_default_out), .char_last_out(char_last_out),
		.char_valid_out(char_valid_out), .char_ready_in(char_ready_in), .done_out(done_out),
		.busy_out(busy_out), .scheme_out(scheme_out));
	afd_src u_src (.clock_in(clock_in), .ready_in(byte_ready_out), .slow_in(slow),
		.byte_out(byte_in), .valid_out(byte_valid_in), .last_out(byte_last_in));
	initial begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end
	// gather taken chars and done pulses
	always @(posedge clock_in) begin
		if (char_valid_out === 1'b1 && char_ready_in) got.push_back({char_last_out, char_default_out, char_out});
		if (done_out === 1'b1) dones++;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic conclude;
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// queue a field, last flag on its final byte
	task automatic send(input logic [7:0] bs[$]);
		foreach (bs[i]) u_src.q.push_back({i == bs.size() - 1, bs[i]});
	endtask
	task automatic want(input logic dflt, input logic [15:0] code);
		exp.push_back({1'b0, dflt, code});
	endtask
	// wait for the string to end, then compare all chars
	// tail low: string closed by a hidden end marker, so no char carries last
	task automatic finish(input string what, input logic [1:0] sch, input logic tail);
		int n;
		n = 0;
		while (dones == 0 && n < 3000) begin
			@(negedge clock_in);
			n++;
		end
		if (dones == 0) begin
			check({what, " done wait"}, dones, 1);
			conclude();
		end
		repeat (2) @(negedge clock_in);
		check({what, " count"}, got.size(), exp.size());
		check({what, " done"}, dones, 1);
		check({what, " scheme"}, scheme_out, sch);
		foreach (exp[i]) check(what, got[i], {tail && i == exp.size() - 1, exp[i][16:0]});
		got.delete();
		exp.delete();
		dones = 0;
	endtask
	task automatic sc_ucs;
		send('{8'h80, 8'h41, 8'h42, 8'hff, 8'hff});
		want(0, 16'h4142);
		finish("pad pair", `AFD_SCH_UCS, 1'b0);
		send('{8'h80, 8'h12, 8'h34, 8'hff});
		want(0, 16'h1234);
		finish("lone pad", `AFD_SCH_UCS, 1'b0);
	endtask
	task automatic sc_half;
		send('{8'h81, 8'h05, 8'h13, 8'h53, 8'h95, 8'ha6, 8'h41, 8'hff, 8'hff});
		want(1, 16'h0053);
		want(0, 16'h0995);
		want(0, 16'h09a6);
		want(1, 16'h0041);
		want(0, 16'h09ff);
		finish("half base", `AFD_SCH_HALF, 1'b1);
	endtask
	// slow source spaces the bytes
	task automatic sc_full;
		slow = 1'b1;
		send('{8'h82, 8'h05, 8'h05, 8'h30, 8'h2d, 8'h82, 8'hd3, 8'h2d, 8'h31});
		want(1, 16'h002d);
		want(0, 16'h0532);
		want(0, 16'h0583);
		want(1, 16'h002d);
		want(1, 16'h0031);
		finish("full base", `AFD_SCH_FULL, 1'b1);
		slow = 1'b0;
		send('{8'h82, 8'h01, 8'h12, 8'h34, 8'hff});
		want(0, 16'h12b3);
		finish("count one", `AFD_SCH_FULL, 1'b1);
		send('{8'h81, 8'h00, 8'h13});
		finish("count zero", `AFD_SCH_HALF, 1'b1);
	endtask
	task automatic sc_dflt;
		send('{8'h41, 8'h42, 8'hff, 8'h43});
		want(1, 16'h0041);
		want(1, 16'h0042);
		finish("default", `AFD_SCH_DEF, 1'b0);
	endtask
	// consumer stalls until the fifo refuses, then drains
	task automatic sc_fill;
		logic [7:0] bs[$];
		int n;
		bs.push_back(8'h80);
		for (int i = 0; i < 18; i++) begin
			bs.push_back(8'h01);
			bs.push_back(i[7:0]);
			want(0, {8'h01, i[7:0]});
		end
		char_ready_in = 1'b0;
		send(bs);
		n = 0;
		while (byte_ready_out !== 1'b0 && n < 100) begin
			@(negedge clock_in);
			n++;
		end
		repeat (4) @(negedge clock_in);
		check("full ready", byte_ready_out, 0);
		check("full head", char_out, 16'h0100);
		char_ready_in = 1'b1;
		finish("fill", `AFD_SCH_UCS, 1'b1);
	endtask
	initial begin
		reset_n_in = 1'b0;
		char_ready_in = 1'b1;
		slow = 1'b0;
		repeat (10) @(negedge clock_in);
		check("reset ready", {byte_ready_out, char_valid_out, done_out, busy_out, scheme_out}, 6'h20);
		reset_n_in = 1'b1;
		sc_ucs();
		sc_half();
		sc_full();
		sc_dflt();
		sc_fill();
		conclude();
	end
endmodule // tb_afd_decoder
`default_nettype wire
